/* sac_pkg.sv */
`default_nettype none
package sac_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register bus request, one cycle per access
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } sac_bus_req_t;

    ////////////////////////////////////////////////////////////////////////
    // register indices
    localparam logic [3:0] REG_SC1   = 4'h0;
    localparam logic [3:0] REG_SC2   = 4'h1;
    localparam logic [3:0] REG_RH    = 4'h2;
    localparam logic [3:0] REG_RL    = 4'h3;
    localparam logic [3:0] REG_CVH   = 4'h4;
    localparam logic [3:0] REG_CVL   = 4'h5;
    localparam logic [3:0] REG_CFG   = 4'h6;
    localparam logic [3:0] REG_PINL  = 4'h7;
    localparam logic [3:0] REG_PINM  = 4'h8;
    localparam logic [3:0] REG_PINH  = 4'h9;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int SC1_FLAG     = 7;
    localparam int SC1_IEN      = 6;
    localparam int SC1_CONT     = 5;
    localparam int SC2_ACTIVE   = 7;
    localparam int SC2_HWTRIG   = 6;
    localparam int SC2_CMPEN    = 5;
    localparam int SC2_GT       = 4;
    localparam int CFG_LP       = 7;
    localparam int CFG_DIV_LSB  = 5;
    localparam int CFG_LSMP     = 4;
    localparam int CFG_MODE_LSB = 2;
    localparam int CFG_CLK_LSB  = 0;

    ////////////////////////////////////////////////////////////////////////
    // encodings and reset values
    localparam logic [1:0] MODE_10BIT = 2'h2;
    localparam logic [1:0] CLK_BUS    = 2'h0;
    localparam logic [1:0] CLK_BUS2   = 2'h1;
    localparam logic [1:0] CLK_ASYNC  = 2'h3;
    localparam logic [4:0] CHAN_OFF   = 5'h1F;
    localparam logic [6:0] SC1_RESET  = 7'h1F;
    localparam logic [2:0] SC2_RESET  = 3'h0;
    localparam logic [7:0] CFG_RESET  = 8'h00;
    localparam logic [9:0] CV_RESET   = 10'h000;
    localparam logic [23:0] PIN_RESET = 24'h00_0000;

    ////////////////////////////////////////////////////////////////////////
    // timing: bus clock 50 MHz
    localparam int CLK_PERIOD_NS = 20;
    localparam int STARTUP_NS    = 5000;
    localparam logic [7:0] STARTUP_CYC =
        8'(STARTUP_NS / CLK_PERIOD_NS);
    localparam logic [7:0] SETUP_CYC   = 8'h05;
    localparam logic [7:0] BITS_8      = 8'h08;
    localparam logic [7:0] BITS_10     = 8'h0A;
    // total conversion-clock cycles per conversion
    localparam logic [7:0] FIRST_S8    = 8'd20;
    localparam logic [7:0] FIRST_S10   = 8'd23;
    localparam logic [7:0] FIRST_L8    = 8'd40;
    localparam logic [7:0] FIRST_L10   = 8'd43;
    localparam logic [7:0] NEXT_S8     = 8'd17;
    localparam logic [7:0] NEXT_S10    = 8'd20;
    localparam logic [7:0] NEXT_L8     = 8'd37;
    localparam logic [7:0] NEXT_L10    = 8'd40;

    ////////////////////////////////////////////////////////////////////////
    // conversion sequencer
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAKE,
        ST_SETUP,
        ST_SAMPLE,
        ST_CONVERT,
        ST_DONE
    } sac_state_t;

endpackage : sac_pkg
`default_nettype wire

/* sac_adc_control.sv */
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module sac_adc_control (
    input  wire logic                  mclk_in,
    input  wire logic                  reset_in,
    input  wire sac_pkg::sac_bus_req_t bus_req_in,
    output logic [7:0]                 rdata_out,
    input  wire logic                  cmp_in,
    input  wire logic                  hw_trig_in,
    input  wire logic                  alt_clk_in,
    output logic [9:0]                 dac_code_out,
    output logic                       sample_out,
    output logic [4:0]                 channel_out,
    output logic                       active_out,
    output logic                       irq_out,
    output logic [23:0]                pin_analog_out
);
    import sac_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // address match, shared by write and read decode
    function automatic logic hit(input sac_bus_req_t r,
                                 input logic [3:0] a);
        hit = (r.addr == a);
    endfunction : hit

    // sample-phase length: total conversion clocks less the bit steps
    function automatic logic [7:0] sample_len(input logic first,
                                              input logic lsmp,
                                              input logic ten);
        logic [7:0] total;
        total = FIRST_S8;
        case ({first, lsmp, ten})
            3'b100:  total = FIRST_S8;
            3'b101:  total = FIRST_S10;
            3'b110:  total = FIRST_L8;
            3'b111:  total = FIRST_L10;
            3'b000:  total = NEXT_S8;
            3'b001:  total = NEXT_S10;
            3'b010:  total = NEXT_L8;
            default: total = NEXT_L10;
        endcase
        sample_len = total - (ten ? BITS_10 : BITS_8);
    endfunction : sample_len

    ////////////////////////////////////////////////////////////////////////
    // register state
    logic [6:0]  sc1_ff;      // irq enable, continuous, channel
    logic [2:0]  sc2_ff;      // hw trigger, compare enable, greater
    logic [9:0]  cv_ff;
    logic [7:0]  cfg_ff;
    logic [23:0] pin_ff;
    logic        flag_ff;
    logic [9:0]  result_ff;
    logic [7:0]  rdata_ff;
    logic        irq_ff;

    // sequencer state
    sac_state_t  state_ff;
    logic [7:0]  cnt_ff;
    logic [3:0]  bit_ff;
    logic [9:0]  trial_ff;
    logic [4:0]  chan_ff;
    logic        first_ff;
    logic        ten_ff;
    logic        lsmp_ff;
    logic        samp_ff;
    logic        active_ff;

    // pin synchronisers: 0 comparator, 1 trigger, 2 alternate clock
    logic [2:0][2:0] sync_ff;
    logic [2:0]      stable_ff;
    logic [2:0]      prev_ff;

    // conversion clock generation
    logic        half_ff;
    logic [2:0]  pre_ff;
    logic        conversion_clock_ff;

    ////////////////////////////////////////////////////////////////////////
    // decode
    logic sc1_wr;
    logic res_rd;
    logic sw_start;
    logic hw_start;
    logic trig_rise;
    logic alt_rise;
    logic done_pass;
    logic [9:0] res_val;
    logic [9:0] cmp_val;

    assign sc1_wr  = bus_req_in.wr && hit(bus_req_in, REG_SC1);
    assign res_rd  = bus_req_in.rd && (hit(bus_req_in, REG_RH) ||
                                       hit(bus_req_in, REG_RL));
    assign trig_rise = stable_ff[1] && !prev_ff[1];
    assign alt_rise  = stable_ff[2] && !prev_ff[2];

    // any write starts, even an unchanged value, unless channel is off or hw trigger is selected
    assign sw_start = sc1_wr && !sc2_ff[SC2_HWTRIG] &&
                      (bus_req_in.wdata[4:0] != CHAN_OFF);
    assign hw_start = trig_rise && sc2_ff[SC2_HWTRIG] &&
                      (sc1_ff[4:0] != CHAN_OFF) && (state_ff == ST_IDLE);

    // 8-bit uses the top eight trial bits; compare on the same width
    assign res_val = ten_ff ? trial_ff : {2'h0, trial_ff[9:2]};
    assign cmp_val = ten_ff ? cv_ff : {2'h0, cv_ff[7:0]};
    // compare strictly beyond the stored value in chosen direction
    assign done_pass = (state_ff == ST_DONE) &&
                       (!sc2_ff[SC2_CMPEN] ||
                        (sc2_ff[SC2_GT] ? (res_val > cmp_val)
                                        : (res_val < cmp_val)));

    ////////////////////////////////////////////////////////////////////////
    // three-stage synchronisers; a level counts once stages 2 and 3 agree
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            sync_ff   <= '0;
            stable_ff <= 3'h0;
            prev_ff   <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                sync_ff[i] <= {sync_ff[i][1:0],
                               (i == 0) ? cmp_in :
                               (i == 1) ? hw_trig_in : alt_clk_in};
                if (sync_ff[i][1] == sync_ff[i][2]) begin
                    stable_ff[i] <= sync_ff[i][2];
                end
            end
            prev_ff <= stable_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // conversion clock: source pick, then divide by 1, 2, 4 or 8.
    // the alternate sources are sampled pins, so they must run well
    // below the bus clock to be seen at all.
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            half_ff <= 1'b0;
            pre_ff  <= 3'h0;
            conversion_clock_ff <= 1'b0;
        end else begin
            logic       src;
            logic [1:0] dv;
            logic [2:0] top;
            half_ff <= !half_ff;
            case (cfg_ff[CFG_CLK_LSB +: 2])
                CLK_BUS:  src = 1'b1;
                CLK_BUS2: src = half_ff;
                default:  src = alt_rise;
            endcase
            dv = cfg_ff[CFG_DIV_LSB +: 2];
            // low power never runs undivided: caps the top speed
            if (cfg_ff[CFG_LP] && (dv == 2'h0)) begin
                dv = 2'h1;
            end
            top = 3'((4'h1 << dv) - 4'h1);
            conversion_clock_ff <= 1'b0;
            if (state_ff == ST_IDLE) begin
                pre_ff <= 3'h0;
            end else if (src) begin
                if (pre_ff >= top) begin
                    pre_ff  <= 3'h0;
                    conversion_clock_ff <= 1'b1;
                end else begin
                    pre_ff <= pre_ff + 3'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software-written registers
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            sc1_ff <= SC1_RESET;
            sc2_ff <= SC2_RESET;
            cv_ff  <= CV_RESET;
            cfg_ff <= CFG_RESET;
            pin_ff <= PIN_RESET;
        end else if (bus_req_in.wr) begin
            case (bus_req_in.addr)
                REG_SC1:  sc1_ff <= bus_req_in.wdata[6:0];
                REG_SC2:  sc2_ff <= bus_req_in.wdata[6:4];
                REG_CVH:  cv_ff[9:8] <= bus_req_in.wdata[1:0];
                REG_CVL:  cv_ff[7:0] <= bus_req_in.wdata;
                REG_CFG:  cfg_ff <= bus_req_in.wdata;
                REG_PINL: pin_ff[7:0] <= bus_req_in.wdata;
                REG_PINM: pin_ff[15:8] <= bus_req_in.wdata;
                REG_PINH: pin_ff[23:16] <= bus_req_in.wdata;
                default:  ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer: wake, bus setup, sample, bit steps, done
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            state_ff  <= ST_IDLE;
            cnt_ff    <= 8'h00;
            bit_ff    <= 4'h0;
            trial_ff  <= 10'h000;
            chan_ff   <= CHAN_OFF;
            first_ff  <= 1'b0;
            ten_ff    <= 1'b0;
            lsmp_ff   <= 1'b0;
            samp_ff   <= 1'b0;
            active_ff <= 1'b0;
        end else if (sw_start || hw_start) begin
            // channel and mode are taken here and again at each continuous restart
            chan_ff   <= sw_start ? bus_req_in.wdata[4:0]
                                  : sc1_ff[4:0];
            ten_ff    <= (cfg_ff[CFG_MODE_LSB +: 2] == MODE_10BIT);
            lsmp_ff   <= cfg_ff[CFG_LSMP];
            first_ff  <= 1'b1;
            samp_ff   <= 1'b0;
            active_ff <= 1'b1;
            if (cfg_ff[CFG_CLK_LSB +: 2] == CLK_ASYNC) begin
                state_ff <= ST_WAKE;
                cnt_ff   <= STARTUP_CYC - 8'h01;
            end else begin
                state_ff <= ST_SETUP;
                cnt_ff   <= SETUP_CYC - 8'h01;
            end
        end else if (sc1_wr) begin
            // a write that does not start aborts the conversion
            state_ff  <= ST_IDLE;
            samp_ff   <= 1'b0;
            active_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_WAKE: begin
                    if (cnt_ff == 8'h00) begin
                        state_ff <= ST_SETUP;
                        cnt_ff   <= SETUP_CYC - 8'h01;
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                ST_SETUP: begin
                    if (cnt_ff == 8'h00) begin
                        state_ff <= ST_SAMPLE;
                        samp_ff  <= 1'b1;
                        cnt_ff   <= sample_len(first_ff, lsmp_ff,
                                               ten_ff) - 8'h01;
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                ST_SAMPLE: begin
                    if (conversion_clock_ff) begin
                        if (cnt_ff == 8'h00) begin
                            state_ff <= ST_CONVERT;
                            samp_ff  <= 1'b0;
                            trial_ff <= 10'h200;
                            bit_ff   <= 4'h9;
                        end else begin
                            cnt_ff <= cnt_ff - 8'h01;
                        end
                    end
                end
                ST_CONVERT: begin
                    // one decision per conversion clock, msb first
                    if (conversion_clock_ff) begin
                        if (!stable_ff[0]) begin
                            trial_ff[bit_ff] <= 1'b0;
                        end
                        if (bit_ff == (ten_ff ? 4'h0 : 4'h2)) begin
                            state_ff <= ST_DONE;
                        end else begin
                            bit_ff <= bit_ff - 4'h1;
                            trial_ff[bit_ff - 4'h1] <= 1'b1;
                        end
                    end
                end
                ST_DONE: begin
                    if (sc1_ff[SC1_CONT]) begin
                        state_ff <= ST_SAMPLE;
                        samp_ff  <= 1'b1;
                        first_ff <= 1'b0;
                        chan_ff  <= sc1_ff[4:0];
                        ten_ff   <= (cfg_ff[CFG_MODE_LSB +: 2] ==
                                     MODE_10BIT);
                        lsmp_ff  <= cfg_ff[CFG_LSMP];
                        cnt_ff   <= sample_len(1'b0,
                                               cfg_ff[CFG_LSMP],
                                               cfg_ff[CFG_MODE_LSB +: 2]
                                               == MODE_10BIT) - 8'h01;
                    end else begin
                        state_ff  <= ST_IDLE;
                        active_ff <= 1'b0;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result: kept only for conversions that pass the compare
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            result_ff <= 10'h000;
        end else if (done_pass) begin
            result_ff <= res_val;
        end
    end

    // completion flag: a set in the same cycle as a clear wins
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            flag_ff <= 1'b0;
        end else if (done_pass) begin
            flag_ff <= 1'b1;
        end else if (res_rd || sc1_wr) begin
            flag_ff <= 1'b0;
        end
    end

    // interrupt request follows the flag one cycle later, gated by the irq enable
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= flag_ff && sc1_ff[SC1_IEN];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data: valid only in the cycle after the strobe
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            rdata_ff <= 8'h00;
        end else if (bus_req_in.rd) begin
            case (bus_req_in.addr)
                REG_SC1:  rdata_ff <= {flag_ff, sc1_ff};
                REG_SC2:  rdata_ff <= {active_ff, sc2_ff, 4'h0};
                REG_RH:   rdata_ff <= {6'h00, result_ff[9:8]};
                REG_RL:   rdata_ff <= result_ff[7:0];
                REG_CVH:  rdata_ff <= {6'h00, cv_ff[9:8]};
                REG_CVL:  rdata_ff <= cv_ff[7:0];
                REG_CFG:  rdata_ff <= cfg_ff;
                REG_PINL: rdata_ff <= pin_ff[7:0];
                REG_PINM: rdata_ff <= pin_ff[15:8];
                REG_PINH: rdata_ff <= pin_ff[23:16];
                default:  rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, each straight from a flop
    assign rdata_out      = rdata_ff;
    assign dac_code_out   = trial_ff;
    assign sample_out     = samp_ff;
    assign channel_out    = chan_ff;
    assign active_out     = active_ff;
    assign irq_out        = irq_ff;
    assign pin_analog_out = pin_ff;

endmodule : sac_adc_control
`default_nettype wire

/* sac_analog_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sac_analog_model
    import sac_pkg::*;
(
    input  wire logic [9:0]  level_in,
    input  wire logic [9:0]  dac_code_in,
    input  wire logic [4:0]  channel_in,
    input  wire logic [23:0] pin_analog_in,
    output logic             cmp_out
);
    logic       pin_sel;
    logic [9:0] pin_level;
    ////////////////////////////////////////////////////////////////////////
    // each pin sits its channel number above the base, so a wrong route shows up
    assign pin_level = level_in + {5'h00, channel_in};
    // a pin left under port control reads as ground, not as the level
    assign pin_sel = (channel_in < 5'h18) && pin_analog_in[channel_in];
    // ideal comparator, combinational on the trial code
    assign cmp_out = (pin_sel ? pin_level : 10'h000) >= dac_code_in;
endmodule : sac_analog_model
`default_nettype wire

/* sac_adc_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module sac_adc_monitor
    import sac_pkg::*;
(
    input wire logic                  mclk_in,
    input wire logic                  reset_in,
    input wire sac_pkg::sac_bus_req_t bus_req_in,
    input wire logic [7:0]            rdata_out,
    input wire logic                  sample_out,
    input wire logic [4:0]            channel_out,
    input wire logic                  active_out,
    input wire logic                  irq_out,
    input wire logic [23:0]           pin_analog_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    logic sc1_wr;
    // a status write may restart and relatch the channel
    assign sc1_wr = bus_req_in.wr && (bus_req_in.addr == REG_SC1);
    ////////////////////////////////////////////////////////////////////////
    a_pin_low: assert property (
        bus_req_in.wr && bus_req_in.addr == REG_PINL |=>
        pin_analog_out[7:0] == $past(bus_req_in.wdata))
        else $error("pin select low not updated");
    a_pin_high: assert property (
        bus_req_in.wr && bus_req_in.addr == REG_PINH |=>
        pin_analog_out[23:16] == $past(bus_req_in.wdata))
        else $error("pin select high not updated");
    a_pin_stable: assert property (
        !$past(bus_req_in.wr) |-> $stable(pin_analog_out))
        else $error("pin select changed without write");
    a_chan_hold: assert property (
        active_out && $past(active_out) && !$past(sc1_wr)
        && !$past(sc1_wr, 2) |-> $stable(channel_out))
        else $error("channel moved during conversion");
    a_sample_active: assert property (sample_out |-> active_out)
        else $error("sampling while not active");
    a_setup_gap: assert property (
        $rose(sample_out) |-> $past(active_out, 4))
        else $error("sampling began before bus setup");
    a_irq_clear: assert property (
        bus_req_in.rd && (!active_out || sample_out)
        && (bus_req_in.addr == REG_RL
        || bus_req_in.addr == REG_RH) |=> ##1 !irq_out)
        else $error("result read left request up");
    a_cv_echo: assert property (
        (bus_req_in.wr && bus_req_in.addr == REG_CVL) ##1 !bus_req_in.wr
        ##1 (bus_req_in.rd && bus_req_in.addr == REG_CVL) |=>
        rdata_out == $past(bus_req_in.wdata, 3))
        else $error("compare value readback wrong");
endmodule : sac_adc_monitor
bind sac_adc_control sac_adc_monitor mon_u (.mclk_in(mclk_in),
    .reset_in(reset_in), .bus_req_in(bus_req_in), .rdata_out(rdata_out),
    .sample_out(sample_out), .channel_out(channel_out),
    .active_out(active_out), .irq_out(irq_out),
    .pin_analog_out(pin_analog_out));
`default_nettype wire

/* sac_adc_control_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module sac_adc_control_tb;
    import sac_pkg::*;
    logic         mclk_in, reset_in, cmp, hw_trig, sample, active, irq;
    sac_bus_req_t bus;
    logic [7:0]   rdata;
    logic [9:0]   dac, level;
    logic [4:0]   chan;
    logic [23:0]  pins;
    int           fails = 0, num_checks = 0, cycles = 0, got_cyc;
    logic         got;
    logic [1:0]   alt_div = 2'h0;
    sac_adc_control dut_u (.mclk_in(mclk_in), .reset_in(reset_in),
        .bus_req_in(bus), .rdata_out(rdata), .cmp_in(cmp),
        .hw_trig_in(hw_trig), .alt_clk_in(alt_div[1]), .dac_code_out(dac),
        .sample_out(sample), .channel_out(chan), .active_out(active),
        .irq_out(irq), .pin_analog_out(pins));
    sac_analog_model pin_u (.level_in(level), .dac_code_in(dac),
        .channel_in(chan), .pin_analog_in(pins), .cmp_out(cmp));
    ////////////////////////////////////////////////////////////////////////
    // clock and the hang guard; a run needs well under 20000 cycles
    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end
    // alternate conversion clock at a quarter of the bus rate, so the
    // design's pin synchroniser sees each level on two samples
    always @(posedge mclk_in) alt_div <= alt_div + 2'h1;
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            $display("Error timeout reached");
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string w, input logic [23:0] s, e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", w, e, s);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_in) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk_in) bus <= '0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk_in) bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge mclk_in) bus <= '0;
        #1 d = rdata;
    endtask : rd
    task automatic rdc(input string w, input logic [3:0] a, logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(w, d, e);
    endtask : rdc
    // software polling of the flag, bounded by the worst conversion time
    task automatic poll(input int lim);
        logic [7:0] d;
        got = 1'b0;
        got_cyc = 0;
        while (!got && got_cyc < lim) begin
            rd(REG_SC1, d);
            got_cyc += 2;
            got = d[SC1_FLAG];
        end
    endtask : poll
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdc("sc1", REG_SC1, 8'h1F);
        chk("channel", chan, 5'h1F);
        rdc("cfg", REG_CFG, 8'h00);
        wr(REG_RH, 8'hFF);
        rdc("rh ro", REG_RH, 8'h00);
        rdc("unmapped", 4'hA, 8'h00);
        wr(REG_PINL, 8'hA5);
        wr(REG_PINM, 8'h3C);
        wr(REG_PINH, 8'h81);
        #1 chk("pins", pins, 24'h81_3CA5);
        rdc("pin mid", REG_PINM, 8'h3C);
        $display("done reset and pins");
    endtask : t_reset
    // divide by 8 gives the synced comparator time to settle per bit
    task automatic conv(input logic lsmp, ten, input logic [9:0] lvl);
        int lim;
        logic [9:0] e;
        lim = ((lsmp ? 40 : 20) + (ten ? 3 : 0)) * 8 + 5 + 8;
        e = lvl + 10'h002;
        level <= lvl;
        wr(REG_CFG, {3'b011, lsmp, ten, 3'b000});
        wr(REG_SC1, 8'h02);
        #1 chk("active", active, 1'b1);
        poll(lim + 40);
        chk("flag", got, 1'b1);
        chk("time", got_cyc <= lim, 1'b1);
        chk("idle", active, 1'b0);
        rdc("rh", REG_RH, ten ? {6'h00, e[9:8]} : 8'h00);
        rdc("rl", REG_RL, ten ? e[7:0] : e[9:2]);
        rdc("cleared", REG_SC1, 8'h02);
        chk("no irq", irq, 1'b0);
        $display("done conversion");
    endtask : conv
    task automatic cmpt(input logic [7:0] sc2, input logic [9:0] lvl, e);
        wr(REG_SC2, sc2);
        level <= lvl;
        wr(REG_SC1, 8'h02);
        poll(400);
        chk("cmp flag", got, e);
        $display("done compare");
    endtask : cmpt
    task automatic t_hw();
        wr(REG_SC2, 8'h40);
        level <= 10'h155;
        wr(REG_SC1, 8'h62);
        #1 chk("held", active, 1'b0);
        @(posedge mclk_in) hw_trig <= 1'b1;
        repeat (4) @(posedge mclk_in);
        hw_trig <= 1'b0;
        poll(420);
        #1 chk("hw flag", got, 1'b1);
        chk("irq", irq, 1'b1);
        rdc("cont rl", REG_RL, 8'h57);
        @(posedge mclk_in) #1 chk("irq off", irq, 1'b0);
        poll(420);
        chk("again", got, 1'b1);
        wr(REG_SC1, 8'h1F);
        @(posedge mclk_in) #1 chk("stopped", active, 1'b0);
        $display("done trigger and continuous");
    endtask : t_hw
    // alternate pin clock halved: the first conversion waits out the
    // startup; low power on that source must not run it undivided
    task automatic t_clk(input logic [7:0] cfg, input int lo, hi);
        wr(REG_SC2, 8'h00);
        level <= 10'h1C8;
        wr(REG_CFG, cfg);
        wr(REG_SC1, 8'h02);
        poll(hi);
        chk("alt flag", got, 1'b1);
        chk("alt slow", got_cyc > lo, 1'b1);
        chk("alt time", got_cyc <= hi, 1'b1);
        rdc("alt rl", REG_RL, 8'h72);
        $display("done clock source");
    endtask : t_clk
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////
    initial begin
        reset_in = 1'b1;
        bus = '0;
        hw_trig = 1'b0;
        level = 10'h000;
        repeat (8) @(posedge mclk_in);
        reset_in <= 1'b0;
        t_reset();
        for (int i = 0; i < 4; i++) begin
            conv(i[1], i[0], 10'h2D7 - 10'(i * 97));
        end
        wr(REG_CVH, 8'h02);
        wr(REG_CVL, 8'h55);
        rdc("cvl", REG_CVL, 8'h55);
        cmpt(8'h30, 10'h100, 1'b0);
        cmpt(8'h30, 10'h300, 1'b1);
        cmpt(8'h20, 10'h100, 1'b1);
        cmpt(8'h20, 10'h300, 1'b0);
        t_hw();
        t_clk(8'h23, 250, 431);
        t_clk(8'h83, 350, 431);
        close_out();
    end
endmodule : sac_adc_control_tb
`default_nettype wire
